// *** rtl/sars_sequencer.sv ***
// The register addresses and the strobed register port were left to the implementer.
`include "sars_params.svh"

module sars_sequencer
  import sars_pkg::*;
#(
  parameter int SettleCycles = `SARS_SETTLE_CYC,
  parameter int DivW = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [15:0] busRdata,
  input wire logic compIn,
  input wire logic globalIrqEnable,
  input wire logic irqServiced,
  output logic irqRequest,
  output logic endOfConversion,
  output logic convClockRun,
  output logic sampleSwitch,
  output logic [2:0] channelSel,
  output logic [3:0] currentSrcEn,
  output logic refSwitchClosed,
  output logic powerDown,
  output logic [13:0] dacCode
);
  localparam int SettleW = $clog2(SettleCycles + 1);

  if (SettleCycles < 1) begin : g_badSettle
    $error("sars_sequencer: SettleCycles must be at least 1");
  end
  if (DivW != 2) begin : g_badDiv
    $error("sars_sequencer: divider field is two bits wide");
  end

  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic irqEnable;
  logic next_irqEnable;
  logic conversionDone;
  logic next_conversionDone;
  logic [SettleW-1:0] settleCnt;
  logic [SettleW-1:0] next_settleCnt;
  logic [15:0] next_busRdata;
  logic biasReady;
  logic ctrlWrite;
  logic startPulse;

  sars_state_t state;
  sars_state_t next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [3:0] pos;
  logic [3:0] next_pos;
  logic [13:0] next_dacCode;
  logic [15:0] resultWord;
  logic [15:0] next_resultWord;
  logic autoMode;
  logic next_autoMode;
  logic next_eoc;
  logic [7:0] convTicks;
  logic [7:0] next_convTicks;
  logic tick;
  logic compSync;

  sars_sync #(.Width(1)) sars_sync_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn(compIn),
    .syncOut(compSync)
  );

  sars_clkdiv #(.RatioW(DivW)) sars_clkdiv_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(convClockRun),
    .ratioSel(ctrl[`SARS_DIV_LSB +: DivW]),
    .tick(tick)
  );

  assign ctrlWrite = busWrite && busAddr == `SARS_ADDR_CTRL;
  assign startPulse = ctrlWrite && busWdata[`SARS_BIT_START];
  assign biasReady = settleCnt == SettleW'(SettleCycles);

  // register file: start and ready bits are never stored
  always_comb begin
    next_ctrl = ctrl;
    next_irqEnable = irqEnable;
    next_conversionDone = conversionDone;
    next_settleCnt = settleCnt;
    next_busRdata = 16'h0000;
    if (ctrlWrite) begin
      next_ctrl = busWdata & 16'h7ffe;
    end
    if (busWrite && busAddr == `SARS_ADDR_IRQ_EN) begin
      next_irqEnable = busWdata[`SARS_IRQ_BIT];
    end
    if (busWrite && busAddr == `SARS_ADDR_IRQ_FLAG) begin
      next_conversionDone = busWdata[`SARS_IRQ_BIT];
    end
    if (irqServiced) begin
      next_conversionDone = 1'b0;
    end
    if (endOfConversion) begin
      next_conversionDone = 1'b1;
    end
    if (ctrl[`SARS_BIT_PDOWN]) begin
      next_settleCnt = '0;
    end else if (!biasReady) begin
      next_settleCnt = settleCnt + 1'b1;
    end
    if (busRead) begin
      if (busAddr == `SARS_ADDR_CTRL) begin
        next_busRdata = ctrl;
        next_busRdata[`SARS_BIT_READY] = biasReady;
      end else if (busAddr == `SARS_ADDR_RESULT) begin
        next_busRdata = resultWord;
      end else if (busAddr == `SARS_ADDR_IRQ_EN) begin
        next_busRdata[`SARS_IRQ_BIT] = irqEnable;
      end else if (busAddr == `SARS_ADDR_IRQ_FLAG) begin
        next_busRdata[`SARS_IRQ_BIT] = conversionDone;
      end else begin
        next_busRdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl <= `SARS_CTRL_RESET;
      irqEnable <= 1'b0;
      conversionDone <= 1'b0;
      settleCnt <= '0;
      busRdata <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      irqEnable <= next_irqEnable;
      conversionDone <= next_conversionDone;
      settleCnt <= next_settleCnt;
      busRdata <= next_busRdata;
    end
  end

  // sequencer: bitCnt counts converter ticks inside a phase or bit slot
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_pos = pos;
    next_dacCode = dacCode;
    next_resultWord = resultWord;
    next_autoMode = autoMode;
    next_eoc = 1'b0;
    next_convTicks = convTicks;
    if (startPulse) begin
      // a restart mid-conversion simply begins again; its data are not trusted
      next_state = SARS_SAMPLE1;
      next_bitCnt = 4'h0;
      next_pos = 4'h0;
      next_autoMode = busWdata[`SARS_BIT_AUTO];
      next_dacCode = 14'h0000;
      if (!busWdata[`SARS_BIT_AUTO]) begin
        next_dacCode[13:12] = busWdata[`SARS_RANGE_LSB +: 2];
      end
      next_resultWord = 16'h0000;
      next_convTicks = 8'h00;
    end else if (state != SARS_IDLE && tick) begin
      next_convTicks = convTicks + 8'h01;
      next_bitCnt = bitCnt + 4'h1;
      case (state)
        SARS_SAMPLE1: begin
          if (bitCnt == 4'(`SARS_SAMPLE_CYC - 1)) begin
            next_bitCnt = 4'h0;
            if (autoMode) begin
              next_state = SARS_RANGE;
              next_pos = 4'd13;
              next_dacCode[13] = 1'b1;
            end else begin
              next_state = SARS_CONVERT;
              next_pos = 4'd11;
              next_dacCode[11] = 1'b1;
            end
          end
        end
        SARS_RANGE: begin
          if (bitCnt == 4'(`SARS_RANGE_BIT_CYC - 1)) begin
            next_bitCnt = 4'h0;
            next_dacCode[pos] = compSync;
            next_resultWord = {2'b00, next_dacCode};
            if (pos == 4'd12) begin
              next_state = SARS_SAMPLE2;
            end else begin
              next_pos = pos - 4'h1;
              next_dacCode[next_pos] = 1'b1;
            end
          end
        end
        SARS_SAMPLE2: begin
          if (bitCnt == 4'(`SARS_SAMPLE_CYC - 1)) begin
            next_bitCnt = 4'h0;
            next_state = SARS_CONVERT;
            next_pos = 4'd11;
            next_dacCode[11] = 1'b1;
          end
        end
        SARS_CONVERT: begin
          if (bitCnt == 4'(`SARS_CONV_BIT_CYC - 1)) begin
            next_bitCnt = 4'h0;
            next_dacCode[pos] = compSync;
            // decided bits show in the result as they resolve
            if (autoMode) begin
              next_resultWord = {2'b00, next_dacCode};
            end else begin
              next_resultWord = {4'h0, next_dacCode[11:0]};
            end
            if (pos == 4'd0) begin
              next_state = SARS_IDLE;
              next_eoc = 1'b1;
            end else begin
              next_pos = pos - 4'h1;
              next_dacCode[next_pos] = 1'b1;
            end
          end
        end
        default: begin
          next_state = SARS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= SARS_IDLE;
      bitCnt <= 4'h0;
      pos <= 4'h0;
      dacCode <= 14'h0000;
      resultWord <= 16'h0000;
      autoMode <= 1'b0;
      endOfConversion <= 1'b0;
      convTicks <= 8'h00;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      pos <= next_pos;
      dacCode <= next_dacCode;
      resultWord <= next_resultWord;
      autoMode <= next_autoMode;
      endOfConversion <= next_eoc;
      convTicks <= next_convTicks;
    end
  end

  assign convClockRun = state != SARS_IDLE;
  // the mux only connects during the two sample phases
  assign sampleSwitch = state == SARS_SAMPLE1 || state == SARS_SAMPLE2;
  assign channelSel = ctrl[`SARS_CHAN_LSB +: 3];
  assign refSwitchClosed = ctrl[`SARS_BIT_REF];
  assign powerDown = ctrl[`SARS_BIT_PDOWN];
  assign irqRequest = conversionDone && irqEnable && globalIrqEnable;

  // one enable plus a two-bit select cannot light two sources
  for (genvar i = 0; i < 4; i++) begin : g_isrc
    assign currentSrcEn[i] = ctrl[`SARS_BIT_ISRC_EN] &&
                             ctrl[`SARS_ISRC_LSB +: 2] == 2'(i);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_eocManual;
    endOfConversion && !autoMode;
  endsequence
  sequence s_eocAuto;
    endOfConversion && autoMode;
  endsequence

  property p_startClears;
    startPulse |=> resultWord == 16'h0000 && state == SARS_SAMPLE1 && convClockRun;
  endproperty
  a_startClears: assert property (p_startClears) else $error("start did not restart");

  property p_manualLength;
    s_eocManual |-> convTicks == 8'(`SARS_MANUAL_TOTAL) && resultWord[15:12] == 4'h0;
  endproperty
  a_manualLength: assert property (p_manualLength) else $error("manual length wrong");

  property p_autoLength;
    s_eocAuto |-> convTicks == 8'(`SARS_AUTO_TOTAL) && resultWord == {2'b00, dacCode};
  endproperty
  a_autoLength: assert property (p_autoLength) else $error("auto length wrong");

  property p_flagSet;
    endOfConversion |=> conversionDone;
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("done flag not set");

  property p_flagClear;
    irqServiced && !endOfConversion && !busWrite |=> !conversionDone;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("service left flag");

  property p_irqGate;
    irqRequest |-> conversionDone && irqEnable && globalIrqEnable;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("ungated interrupt");

  property p_clockHeld;
    !convClockRun && !startPulse |=> !convClockRun && !tick;
  endproperty
  a_clockHeld: assert property (p_clockHeld) else $error("clock ran while idle");

  property p_manualRange;
    convClockRun && !autoMode && !startPulse |=> $stable(dacCode[13:12]);
  endproperty
  a_manualRange: assert property (p_manualRange) else $error("manual range moved");

  property p_muxOff;
    state == SARS_CONVERT || state == SARS_RANGE |-> !sampleSwitch;
  endproperty
  a_muxOff: assert property (p_muxOff) else $error("mux on after sampling");

  property p_oneSource;
    $onehot0(currentSrcEn);
  endproperty
  a_oneSource: assert property (p_oneSource) else $error("two current sources");

  property p_refFollows;
    ctrlWrite |=> refSwitchClosed == $past(busWdata[`SARS_BIT_REF]);
  endproperty
  a_refFollows: assert property (p_refFollows) else $error("reference switch wrong");
endmodule

// *** rtl/sars_params.svh ***
`ifndef SARS_PARAMS_SVH
`define SARS_PARAMS_SVH

// register byte addresses on the plain register port
`define SARS_ADDR_CTRL 16'h0114
`define SARS_ADDR_RESULT 16'h0118
`define SARS_ADDR_IRQ_EN 16'h0120
`define SARS_ADDR_IRQ_FLAG 16'h0124

// converter_control_word layout
`define SARS_CTRL_RESET 16'h0002
`define SARS_BIT_START 0
`define SARS_BIT_PDOWN 1
`define SARS_CHAN_LSB 2
`define SARS_BIT_ISRC_EN 5
`define SARS_ISRC_LSB 6
`define SARS_RANGE_LSB 9
`define SARS_BIT_AUTO 11
`define SARS_BIT_REF 12
`define SARS_DIV_LSB 13
`define SARS_BIT_READY 15

// bit 2 of the second irq flag and enable registers
`define SARS_IRQ_BIT 2

// phase lengths in converter_clock cycles
`define SARS_SAMPLE_CYC 12
`define SARS_RANGE_CYC 24
`define SARS_RANGE_BITS 2
`define SARS_CONV_CYC 84
`define SARS_CONV_BITS 12
`define SARS_RANGE_BIT_CYC (`SARS_RANGE_CYC / `SARS_RANGE_BITS)
`define SARS_CONV_BIT_CYC (`SARS_CONV_CYC / `SARS_CONV_BITS)
`define SARS_MANUAL_TOTAL 96
`define SARS_AUTO_TOTAL 132

// bias settling after leaving power-down
`define SARS_SETTLE_NS 6000
`define SARS_CLK_PERIOD_NS 10
`define SARS_SETTLE_CYC ((`SARS_SETTLE_NS + `SARS_CLK_PERIOD_NS - 1) / `SARS_CLK_PERIOD_NS)

`endif

// *** rtl/sars_pkg.sv ***
package sars_pkg;
  typedef enum logic [2:0] {
    SARS_IDLE = 3'b000,
    SARS_SAMPLE1 = 3'b001,
    SARS_RANGE = 3'b010,
    SARS_SAMPLE2 = 3'b011,
    SARS_CONVERT = 3'b100
  } sars_state_t;
endpackage

// *** rtl/sars_sync.sv ***
module sars_sync #(
  parameter int Width = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [Width-1:0] asyncIn,
  output logic [Width-1:0] syncOut
);
  logic [Width-1:0] stage1;

  if (Width < 1) begin : g_badWidth
    $error("sars_sync: Width must be at least 1");
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// *** rtl/sars_clkdiv.sv ***
module sars_clkdiv #(
  parameter int RatioW = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [RatioW-1:0] ratioSel,
  output logic tick
);
  logic [RatioW-1:0] cnt;
  logic [RatioW-1:0] next_cnt;
  logic next_tick;

  if (RatioW < 1) begin : g_badRatio
    $error("sars_clkdiv: RatioW must be at least 1");
  end

  // ratio is field value plus one; a stopped divider restarts from zero
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt == ratioSel) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  property p_tickOnTime;
    @(posedge mclk) disable iff (sys_rst)
    run && cnt == ratioSel |=> tick;
  endproperty
  a_tickOnTime: assert property (p_tickOnTime) else $error("divider tick missing");

  property p_noEarlyTick;
    @(posedge mclk) disable iff (sys_rst)
    tick |-> $past(cnt) == ratioSel && $past(run);
  endproperty
  a_noEarlyTick: assert property (p_noEarlyTick) else $error("divider tick too early");
endmodule

// *** test/tb_sars_sequencer.sv ***
`include "sars_params.svh"

module tb_sars_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic autoMode;
    logic [1:0] range;
    logic [1:0] div;
    logic comp;
    logic [15:0] result;
  } sars_row_t;

  // comparator held steady: 1 keeps every trial bit, 0 drops every one
  sars_row_t rows [6] = '{
    '{1'h0, 2'h0, 2'h0, 1'h1, 16'h0fff},
    '{1'h0, 2'h1, 2'h1, 1'h0, 16'h0000},
    '{1'h0, 2'h2, 2'h2, 1'h1, 16'h0fff},
    '{1'h0, 2'h3, 2'h3, 1'h1, 16'h0fff},
    '{1'h1, 2'h0, 2'h0, 1'h1, 16'h3fff},
    '{1'h1, 2'h0, 2'h3, 1'h0, 16'h0000}
  };

  logic mclk, sysRst, busWrite, busRead, compIn, globalIrqEnable, irqServiced;
  logic [15:0] busAddr, busWdata, busRdata, ctrl;
  logic irqRequest, endOfConversion, convClockRun, sampleSwitch, refSwitchClosed, powerDown;
  logic [2:0] channelSel;
  logic [3:0] currentSrcEn;
  logic [13:0] dacCode;
  int n_errors, checks, cycles, edges, total;
  sars_row_t r;

  sars_sequencer #(.SettleCycles(4), .DivW(2)) sars_sequencer_inst (
    .mclk(mclk), .sys_rst(sysRst), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata), .compIn(compIn),
    .globalIrqEnable(globalIrqEnable), .irqServiced(irqServiced),
    .irqRequest(irqRequest), .endOfConversion(endOfConversion),
    .convClockRun(convClockRun), .sampleSwitch(sampleSwitch), .channelSel(channelSel),
    .currentSrcEn(currentSrcEn), .refSwitchClosed(refSwitchClosed),
    .powerDown(powerDown), .dacCode(dacCode)
  );

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge mclk);
    busWrite <= 1'h1;
    busAddr <= addr;
    busWdata <= data;
    @(posedge mclk);
    busWrite <= 1'h0;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] addr, input logic [15:0] exp);
    @(posedge mclk);
    busRead <= 1'h1;
    busAddr <= addr;
    @(posedge mclk);
    busRead <= 1'h0;
    #1;
    check(what, exp, busRdata);
  endtask

  // start is taken at the write edge; edges counts clock edges until the end pulse
  task automatic convert(input logic [15:0] word);
    wr(`SARS_ADDR_CTRL, word);
    #1;
    check("run", 16'h0001, {15'h0, convClockRun});
    check("dac", word[11] ? 16'h0000 : {2'h0, word[10:9], 12'h000}, {2'h0, dacCode});
    edges = 0;
    while (endOfConversion !== 1'h1 && edges < 700) begin
      @(posedge mclk);
      #1;
      edges++;
    end
    check("run off", 16'h0000, {15'h0, convClockRun});
  endtask

  // outputs are read after the wait, never when the wait is called
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    cycles = 0;
    forever begin
      @(posedge mclk);
      cycles++;
      if (cycles == 8000) begin
        n_errors++;
        wrap_up();
      end
    end
  end

  initial begin
    n_errors = 0;
    checks = 0;
    sysRst = 1'h1;
    busWrite = 1'h0;
    busRead = 1'h0;
    busAddr = 16'h0000;
    busWdata = 16'h0000;
    compIn = 1'h0;
    globalIrqEnable = 1'h1;
    irqServiced = 1'h0;
    repeat (4) @(posedge mclk);
    sysRst <= 1'h0;
    rd_chk("ctrl rst", `SARS_ADDR_CTRL, `SARS_CTRL_RESET);
    rd_chk("result rst", `SARS_ADDR_RESULT, 16'h0000);
    rd_chk("irq en rst", `SARS_ADDR_IRQ_EN, 16'h0000);
    rd_chk("flag rst", `SARS_ADDR_IRQ_FLAG, 16'h0000);
    check("pd rst", 16'h0001, {15'h0, powerDown});
    // software waits out the bias settling before any start
    wr(`SARS_ADDR_CTRL, 16'h0000);
    repeat (10) @(posedge mclk);
    rd_chk("ready", `SARS_ADDR_CTRL, 16'h8000);

    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      compIn <= r.comp;
      ctrl = {1'h0, r.div, i[0], r.autoMode, r.range, 4'h0, 3'(i), 2'h1};
      wr(`SARS_ADDR_IRQ_FLAG, 16'h0000);
      wr(`SARS_ADDR_IRQ_EN, {13'h0, i[0], 2'h0});
      // manual rows leave the range bits untouched until the end pulse; auto rows resolve them
      convert(ctrl);
      total = r.autoMode ? `SARS_AUTO_TOTAL : `SARS_MANUAL_TOTAL;
      check("cycles", 16'(total * (r.div + 1) + 1), 16'(edges));
      check("chan", {13'h0, 3'(i)}, {13'h0, channelSel});
      check("ref", {15'h0, i[0]}, {15'h0, refSwitchClosed});
      @(posedge mclk);
      #1;
      check("irq", {15'h0, i[0]}, {15'h0, irqRequest});
      rd_chk("flag", `SARS_ADDR_IRQ_FLAG, 16'h0004);
      rd_chk("result", `SARS_ADDR_RESULT, r.result);
    end

    // the result holds while idle, the clock stays stopped, a new start wipes it
    compIn <= 1'h1;
    convert(16'h0001);
    repeat (20) begin
      @(posedge mclk);
      #1;
      check("idle run", 16'h0000, {15'h0, convClockRun});
    end
    rd_chk("held", `SARS_ADDR_RESULT, 16'h0fff);
    wr(`SARS_ADDR_CTRL, 16'h0001);
    rd_chk("cleared", `SARS_ADDR_RESULT, 16'h0000);
    repeat (5) @(posedge mclk);
    #1;
    check("sample on", 16'h0001, {15'h0, sampleSwitch});
    repeat (20) @(posedge mclk);
    #1;
    check("sample off", 16'h0000, {15'h0, sampleSwitch});
    check("still run", 16'h0001, {15'h0, convClockRun});
    repeat (85) @(posedge mclk);
    rd_chk("new", `SARS_ADDR_RESULT, 16'h0fff);

    wr(`SARS_ADDR_IRQ_EN, 16'h0000);
    settle();
    check("irq en off", 16'h0000, {15'h0, irqRequest});
    wr(`SARS_ADDR_IRQ_EN, 16'h0004);
    settle();
    check("irq on", 16'h0001, {15'h0, irqRequest});
    globalIrqEnable <= 1'h0;
    settle();
    check("irq gie", 16'h0000, {15'h0, irqRequest});
    globalIrqEnable <= 1'h1;
    @(posedge mclk);
    irqServiced <= 1'h1;
    @(posedge mclk);
    irqServiced <= 1'h0;
    rd_chk("serviced", `SARS_ADDR_IRQ_FLAG, 16'h0000);

    wr(16'h0200, 16'hffff);
    rd_chk("unmapped", 16'h0200, 16'h0000);
    wr(`SARS_ADDR_RESULT, 16'h1234);
    rd_chk("result ro", `SARS_ADDR_RESULT, 16'h0fff);
    wr(`SARS_ADDR_CTRL, 16'h00a0);
    settle();
    check("isrc", 16'h0004, {12'h0, currentSrcEn});
    wr(`SARS_ADDR_CTRL, 16'h0002);
    settle();
    check("isrc off", 16'h0000, {12'h0, currentSrcEn});
    check("pd", 16'h0001, {15'h0, powerDown});

    wr(`SARS_ADDR_CTRL, 16'h1000);
    sysRst <= 1'h1;
    repeat (2) @(posedge mclk);
    sysRst <= 1'h0;
    rd_chk("ctrl rst2", `SARS_ADDR_CTRL, `SARS_CTRL_RESET);
    check("ref rst2", 16'h0000, {15'h0, refSwitchClosed});
    check("pd rst2", 16'h0001, {15'h0, powerDown});
    wrap_up();
  end
endmodule
